//--- hw/tsl_throttle_regs.sv
// Throttle source flags and input limit readback registers behind a two-wire target
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Input-voltage flag plus enable holds alert low
// - Comparator flag sets, stays until host read
// - Critical-current flag latched until host read
// - Nominal-current flag latched until host read
// - Discharge-current flag latched until host read
// - System-voltage flag latched until host read
// - Battery-removal flag latched until host read
// - Adapter-removal flag latched until host read
// - Readback shows limit in force, host or optimizer
// - Optimizer result is reported once it runs
// - Code bits six to zero, binary weighted
// - Readback upper bit seven reads zero
// - Readback loads 4100h at reset
// - Readback low byte reserved, reads zero
module tsl_throttle_regs
    import tsl_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [FLAG_COUNT-1:0] throttle_src_event,
    input wire logic vin_limit_profile_enable,
    input wire logic [6:0] host_input_limit,
    input wire logic host_limit_load,
    input wire logic [6:0] ico_limit,
    input wire logic ico_result_load,
    output logic throttle_alert_pin_n
);
    tsl_regport_if rp ();                    // Byte port from the serial engine
    logic [FLAG_COUNT-1:0] flags_reg;        // Latched source flags
    logic [FLAG_COUNT-1:0] flags_next;
    logic [FLAG_COUNT-1:0] flag_clr;         // Per-flag clear request
    logic [6:0] limit_reg;                   // Limit code in force
    logic [6:0] limit_next;
    logic alert_n_reg;                       // Alert pin, low is asserted

    // Serial engine owns the pins and the byte pointer
    tsl_i2c_target #(
        .DEV_ADDR(DEV_ADDR)
    ) u_target (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .rp(rp)
    );

    // Access decode
    wire flags_rd_hit = rp.rd_stb & (rp.addr == ADDR_FLAGS);
    wire flags_wr_hit = rp.wr_stb & (rp.addr == ADDR_FLAGS);
    // Only a written zero in the vin bit clears it; other written bits are dropped
    wire vin_clear = flags_wr_hit & ~rp.wdata[VIN_FLAG_BIT];

    // Per-flag latch: a trigger in the clearing cycle wins, so no event is lost
    genvar gi;
    for (gi = 0; gi < FLAG_COUNT; gi++) begin : g_flag
        assign flag_clr[gi] = (gi == VIN_FLAG_BIT) ? vin_clear : flags_rd_hit;
        assign flags_next[gi] = throttle_src_event[gi] | (flags_reg[gi] & ~flag_clr[gi]);
    end

    // Optimizer result outranks a host update in the same cycle
    assign limit_next = ico_result_load ? ico_limit :
                        host_limit_load ? host_input_limit : limit_reg;

    // Read data; the upper status byte is outside this block and reads zero
    wire [7:0] limit_hi_byte = {1'b0, limit_reg};
    assign rp.rdata = (rp.addr == ADDR_FLAGS) ? flags_reg :
                      (rp.addr == ADDR_LIMIT_HI) ? limit_hi_byte : RESERVED_BYTE;

    // Alert output lags the flag by one cycle so it comes from a flop
    wire alert_n_next = ~(flags_reg[VIN_FLAG_BIT] & vin_limit_profile_enable);

    // State registers, frozen while clk_en is low
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flags_reg <= FLAGS_RESET;
            limit_reg <= LIMIT_RESET[LIMIT_CODE_MSB:LIMIT_CODE_LSB];
            alert_n_reg <= 1'b1;
        end else if (clk_en) begin
            flags_reg <= flags_next;
            limit_reg <= limit_next;
            alert_n_reg <= alert_n_next;
        end
    end

    assign throttle_alert_pin_n = alert_n_reg;

    // Checks on the bank
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    property p_alert_low;
        clk_en && flags_reg[VIN_FLAG_BIT] && vin_limit_profile_enable |=> !throttle_alert_pin_n;
    endproperty
    a_alert_low: assert property (p_alert_low)
        else $error("alert pin not low with vin flag and enable set");

    // The pin must also let go once either the flag or the enable drops
    property p_alert_high;
        clk_en && !(flags_reg[VIN_FLAG_BIT] && vin_limit_profile_enable) |=> throttle_alert_pin_n;
    endproperty
    a_alert_high: assert property (p_alert_high)
        else $error("alert pin low without vin flag and enable");

    // One cycle at a time, so a clear right after the check cycle is not flagged
    property p_vin_hold;
        flags_reg[VIN_FLAG_BIT] && !vin_clear |=> flags_reg[VIN_FLAG_BIT];
    endproperty
    a_vin_hold: assert property (p_vin_hold)
        else $error("vin flag dropped without a zero write");

    property p_vin_clear;
        vin_clear && !throttle_src_event[VIN_FLAG_BIT] |=> !flags_reg[VIN_FLAG_BIT];
    endproperty
    a_vin_clear: assert property (p_vin_clear)
        else $error("zero write did not clear vin flag");

    property p_comp_set;
        clk_en && throttle_src_event[6] |=> flags_reg[6];
    endproperty
    a_comp_set: assert property (p_comp_set)
        else $error("comparator flag not set");

    property p_comp_read_clear;
        flags_rd_hit && !throttle_src_event[6] |=> !flags_reg[6];
    endproperty
    a_comp_read_clear: assert property (p_comp_read_clear)
        else $error("comparator flag survived a read");

    property p_rd_clear_low;
        flags_rd_hit && throttle_src_event[5:0] == 6'h00 |=> flags_reg[5:0] == 6'h00;
    endproperty
    a_rd_clear_low: assert property (p_rd_clear_low)
        else $error("latched flag survived a read");

    property p_crit_set;
        clk_en && throttle_src_event[5] |=> flags_reg[5];
    endproperty
    a_crit_set: assert property (p_crit_set)
        else $error("critical current flag not set");

    property p_nom_set;
        clk_en && throttle_src_event[4] |=> flags_reg[4];
    endproperty
    a_nom_set: assert property (p_nom_set)
        else $error("nominal current flag not set");

    property p_dchg_hold;
        flags_reg[3] && !flags_rd_hit |=> flags_reg[3];
    endproperty
    a_dchg_hold: assert property (p_dchg_hold)
        else $error("discharge flag dropped without a read");

    property p_dchg_set;
        clk_en && throttle_src_event[3] |=> flags_reg[3];
    endproperty
    a_dchg_set: assert property (p_dchg_set)
        else $error("discharge flag not set");

    property p_vsys_set;
        clk_en && throttle_src_event[2] |=> flags_reg[2];
    endproperty
    a_vsys_set: assert property (p_vsys_set)
        else $error("system voltage flag not set");

    property p_bat_set;
        clk_en && throttle_src_event[1] |=> flags_reg[1];
    endproperty
    a_bat_set: assert property (p_bat_set)
        else $error("battery removal flag not set");

    property p_adpt_set;
        clk_en && throttle_src_event[0] |=> flags_reg[0];
    endproperty
    a_adpt_set: assert property (p_adpt_set)
        else $error("adapter removal flag not set");

    property p_host_limit;
        clk_en && host_limit_load && !ico_result_load |=> limit_reg == $past(host_input_limit);
    endproperty
    a_host_limit: assert property (p_host_limit)
        else $error("host limit not reported");

    property p_ico_limit;
        clk_en && ico_result_load |=> limit_reg == $past(ico_limit);
    endproperty
    a_ico_limit: assert property (p_ico_limit)
        else $error("optimizer limit not reported");

    property p_hi_byte;
        rp.rd_stb && rp.addr == ADDR_LIMIT_HI |-> rp.rdata[7] == 1'b0 && rp.rdata[6:0] == limit_reg;
    endproperty
    a_hi_byte: assert property (p_hi_byte)
        else $error("readback upper byte wrong");

    property p_reset_value;
        $past(sys_rst) |-> limit_reg == LIMIT_RESET[LIMIT_CODE_MSB:LIMIT_CODE_LSB];
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("readback not at reset value");

    property p_lo_byte;
        rp.rd_stb && rp.addr == ADDR_LIMIT_LO |-> rp.rdata == RESERVED_BYTE;
    endproperty
    a_lo_byte: assert property (p_lo_byte)
        else $error("readback low byte not zero");

    property p_limit_wr_ignored;
        rp.wr_stb && !host_limit_load && !ico_result_load |=> $stable(limit_reg);
    endproperty
    a_limit_wr_ignored: assert property (p_limit_wr_ignored)
        else $error("host write changed the readback");
endmodule
`default_nettype wire

//--- hw/tsl_pkg.sv
// Package: register map, reset values and engine states for the throttle status block
`default_nettype none
package tsl_pkg;
    localparam logic [7:0] ADDR_FLAGS = 8'h22;        // Throttle source flags
    localparam logic [7:0] ADDR_STATUS_HI = 8'h23;    // Upper status byte, not held here
    localparam logic [7:0] ADDR_LIMIT_LO = 8'h24;     // Readback low byte, reserved
    localparam logic [7:0] ADDR_LIMIT_HI = 8'h25;     // Readback high byte, limit code
    localparam logic [7:0] FLAGS_RESET = 8'h00;       // All sources untriggered
    localparam logic [15:0] LIMIT_RESET = 16'h4100;   // Readback value after reset
    localparam logic [7:0] RESERVED_BYTE = 8'h00;     // What reserved bytes read as
    localparam int FLAG_COUNT = 8;                    // One flag per throttle source
    localparam int VIN_FLAG_BIT = 7;                  // Write-zero-to-clear flag
    localparam int LIMIT_CODE_MSB = 14;               // Code field inside the 16-bit word
    localparam int LIMIT_CODE_LSB = 8;
    localparam logic [3:0] BYTE_BITS = 4'h8;          // Bits per serial byte
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;  // Target address, value arbitrary

    // Serial engine states
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
    } tsl_i2c_state_t;
endpackage
`default_nettype wire

//--- hw/tsl_regport_if.sv
// Interface: byte-wide register access between the serial engine and the register bank
`timescale 1ns/1ns
`default_nettype none
interface tsl_regport_if;
    logic rd_stb;        // One-cycle read of the byte at addr
    logic wr_stb;        // One-cycle write of wdata to addr
    logic [7:0] addr;    // Byte pointer
    logic [7:0] wdata;   // Byte written by the host
    logic [7:0] rdata;   // Byte presented for reading, combinational

    modport target (output rd_stb, output wr_stb, output addr, output wdata, input rdata);
    modport regs (input rd_stb, input wr_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

//--- hw/tsl_i2c_target.sv
// Serial two-wire target: turns host frames into byte reads and writes on the register port
`timescale 1ns/1ns
`default_nettype none
module tsl_i2c_target
    import tsl_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    tsl_regport_if.target rp
);
    tsl_i2c_state_t state_reg;   // Frame position
    logic scl_q;                 // Previous line levels for edge detection
    logic sda_q;
    logic [3:0] bitcnt_reg;      // Bits moved in the current byte
    logic [7:0] shreg_reg;       // Shift register, both directions
    logic rw_reg;                // Direction bit of the address byte
    logic [7:0] ptr_reg;         // Register pointer, auto-increments
    logic oe_n_reg;              // Low pulls the data line down
    logic zero_reg;              // Open drain only ever drives low

    // Line events; inputs are already synchronous to clk_sys
    wire scl_rise = scl_in & ~scl_q;
    wire scl_fall = ~scl_in & scl_q;
    wire bus_start = scl_in & scl_q & sda_q & ~sda_in;
    wire bus_stop = scl_in & scl_q & ~sda_q & sda_in;
    wire byte_done = scl_fall & (bitcnt_reg == BYTE_BITS);
    wire rx_state = (state_reg == ST_ADDR) | (state_reg == ST_CMD) | (state_reg == ST_WR);
    wire addr_match = (shreg_reg[7:1] == DEV_ADDR);
    // Byte fetched on the falling edge that starts each read byte
    wire rd_fire = clk_en & scl_fall & (((state_reg == ST_ADDR_ACK) & rw_reg) | (state_reg == ST_RD_ACK));
    wire wr_fire = clk_en & byte_done & (state_reg == ST_WR);

    assign rp.rd_stb = rd_fire;
    assign rp.wr_stb = wr_fire;
    assign rp.addr = ptr_reg;
    assign rp.wdata = shreg_reg;
    assign sda_oe_n = oe_n_reg;
    assign sda_out = zero_reg;

    // Frame sequencer; start and stop override any byte in flight
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bitcnt_reg <= 4'h0;
            shreg_reg <= 8'h00;
            rw_reg <= 1'b0;
            ptr_reg <= 8'h00;
            oe_n_reg <= 1'b1;
            zero_reg <= 1'b0;
        end else if (clk_en) begin
            scl_q <= scl_in;
            sda_q <= sda_in;
            if (bus_start) begin
                state_reg <= ST_ADDR;
                bitcnt_reg <= 4'h0;
                oe_n_reg <= 1'b1;
            end else if (bus_stop) begin
                state_reg <= ST_IDLE;
                oe_n_reg <= 1'b1;
            end else if (rd_fire) begin
                // First bit goes out now, the rest on later falling edges
                shreg_reg <= {rp.rdata[6:0], 1'b0};
                oe_n_reg <= rp.rdata[7];
                ptr_reg <= ptr_reg + 8'h01;
                bitcnt_reg <= 4'h1;
                state_reg <= ST_RD;
            end else if (rx_state && scl_rise) begin
                shreg_reg <= {shreg_reg[6:0], sda_in};
                bitcnt_reg <= bitcnt_reg + 4'h1;
            end else begin
                case (state_reg)
                    ST_ADDR: begin
                        if (byte_done) begin
                            bitcnt_reg <= 4'h0;
                            oe_n_reg <= ~addr_match;
                            rw_reg <= shreg_reg[0];
                            state_reg <= addr_match ? ST_ADDR_ACK : ST_IDLE;
                        end
                    end
                    ST_CMD: begin
                        if (byte_done) begin
                            bitcnt_reg <= 4'h0;
                            ptr_reg <= shreg_reg;
                            oe_n_reg <= 1'b0;
                            state_reg <= ST_CMD_ACK;
                        end
                    end
                    ST_WR: begin
                        if (byte_done) begin
                            bitcnt_reg <= 4'h0;
                            ptr_reg <= ptr_reg + 8'h01;
                            oe_n_reg <= 1'b0;
                            state_reg <= ST_WR_ACK;
                        end
                    end
                    ST_ADDR_ACK: begin
                        // Read direction is taken by rd_fire above
                        if (scl_fall) begin
                            oe_n_reg <= 1'b1;
                            state_reg <= ST_CMD;
                        end
                    end
                    ST_CMD_ACK, ST_WR_ACK: begin
                        if (scl_fall) begin
                            oe_n_reg <= 1'b1;
                            state_reg <= ST_WR;
                        end
                    end
                    ST_RD: begin
                        if (byte_done) begin
                            // Release the line for the host's acknowledge
                            oe_n_reg <= 1'b1;
                            bitcnt_reg <= 4'h0;
                            state_reg <= ST_RD_ACK;
                        end else if (scl_fall) begin
                            oe_n_reg <= shreg_reg[7];
                            shreg_reg <= {shreg_reg[6:0], 1'b0};
                            bitcnt_reg <= bitcnt_reg + 4'h1;
                        end
                    end
                    ST_RD_ACK: begin
                        // A not-acknowledge ends the read; wait for stop
                        if (scl_rise && sda_in) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- test/tsl_host_model.sv
// Two-wire bus host model that frames register reads and writes toward the block
`timescale 1ns/1ns
`default_nettype none
module tsl_host_model
    import tsl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    // Idle: clock stands high, data released to its pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // All line changes happen just after a falling edge, away from the sampling edge
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Start or repeated start: data falls while the clock is high
    task automatic bus_start();
        sda_low = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(3);
        sda_low = 1'b1;
        tick(3);
        scl = 1'b0;
        tick(2);
    endtask

    // Stop: data rises while the clock is high, then the bus idles
    task automatic bus_stop();
        sda_low = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(3);
        sda_low = 1'b0;
        tick(3);
    endtask

    // One clock pulse; low and high phases last at least two cycles each
    task automatic clock_bit(input logic drive_low, output logic seen);
        sda_low = drive_low;
        tick(2);
        scl = 1'b1;
        tick(2);
        seen = sda_line;
        tick(1);
        scl = 1'b0;
        tick(1);
    endtask

    // Eight data bits most significant first, then the acknowledge slot
    task automatic xfer_byte(input logic [7:0] tx, input logic host_ack, output logic [7:0] rx, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(~tx[i], seen);
            rx[i] = seen;
        end
        clock_bit(host_ack, seen);
        ack = ~seen;
    endtask

    // Pointer then one data byte; ok is low if any byte went unanswered
    task automatic reg_write(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] data, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2;
        bus_start();
        xfer_byte({dev, 1'b0}, 1'b0, rx, a0);
        xfer_byte(ptr, 1'b0, rx, a1);
        xfer_byte(data, 1'b0, rx, a2);
        bus_stop();
        ok = a0 & a1 & a2;
    endtask

    // Two bytes from ptr, low byte first; the host refuses the last one to end the read
    task automatic reg_read(input logic [7:0] ptr, output logic [15:0] data);
        logic [7:0] rx0, rx1;
        logic a;
        bus_start();
        xfer_byte({DEV_ADDR_DEFAULT, 1'b0}, 1'b0, rx0, a);
        xfer_byte(ptr, 1'b0, rx0, a);
        bus_start();
        xfer_byte({DEV_ADDR_DEFAULT, 1'b1}, 1'b0, rx0, a);
        xfer_byte(8'hff, 1'b1, rx0, a);
        xfer_byte(8'hff, 1'b0, rx1, a);
        bus_stop();
        data = {rx1, rx0};
    endtask

    // Host reading of a limit code in mA; sense select 1 is the smaller resistor
    function automatic int limit_ma(input logic [6:0] code, input logic sense_sel, input logic maximum);
        int unit;
        unit = sense_sel ? 100 : 50;
        if (code == 7'h00) begin
            return maximum ? 3 * unit : unit;
        end
        return int'(code) * unit + (maximum ? 2 * unit : 0);
    endfunction
endmodule
`default_nettype wire

//--- test/tsl_throttle_regs_bench.sv
// Self-checking bench for the throttle flags and input limit readback registers
`timescale 1ns/1ns
`default_nettype none
module tsl_throttle_regs_bench
    import tsl_pkg::*;
;
    logic clk_sys, sys_rst, clk_en, vin_en, host_load, ico_load, scl, sda_low, sda_oe_n, sda_out, alert_n;
    logic [7:0] src_event;
    logic [6:0] host_lim, ico_lim;
    wire logic sda_line;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;

    // Resolved open-drain data line: low if either party pulls, else the pull-up wins
    assign sda_line = ~(sda_low | (~sda_oe_n & ~sda_out));

    tsl_throttle_regs tsl_throttle_regs_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .throttle_src_event(src_event),
        .vin_limit_profile_enable(vin_en), .host_input_limit(host_lim), .host_limit_load(host_load),
        .ico_limit(ico_lim), .ico_result_load(ico_load), .throttle_alert_pin_n(alert_n)
    );

    tsl_host_model tsl_host_model_inst (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

    // 10 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Hang guard; the whole run needs roughly 9350 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle source pulse, then let the flag and the alert pin settle
    task automatic pulse(input logic [7:0] mask);
        src_event = mask;
        @(negedge clk_sys);
        src_event = 8'h00;
        repeat (2) @(negedge clk_sys);
    endtask

    task automatic t_reset();
        logic [15:0] d;
        tsl_host_model_inst.reg_read(ADDR_FLAGS, d);
        check(16'(d[7:0]), 16'(FLAGS_RESET));
        tsl_host_model_inst.reg_read(ADDR_LIMIT_LO, d);
        check(d, LIMIT_RESET);
        check(16'(alert_n), 16'h0001);
    endtask

    // Each read-cleared source alone: latched across idle time, gone after one read
    task automatic t_latched();
        logic [15:0] d;
        logic ok;
        for (int i = 0; i < 7; i++) begin
            pulse(8'h01 << i);
            tsl_host_model_inst.reg_read(ADDR_FLAGS, d);
            check(16'(d[7:0]), 16'h0001 << i);
            tsl_host_model_inst.reg_read(ADDR_FLAGS, d);
            check(16'(d[7:0]), 16'h0000);
        end
        pulse(8'h7f);
        tsl_host_model_inst.reg_write(DEV_ADDR_DEFAULT, ADDR_FLAGS, 8'h00, ok);
        tsl_host_model_inst.reg_read(ADDR_FLAGS, d);
        check(16'({ok, d[7:0]}), 16'h017f);
        tsl_host_model_inst.reg_write(DEV_ADDR_DEFAULT, ADDR_FLAGS, 8'hff, ok);
        tsl_host_model_inst.reg_read(ADDR_FLAGS, d);
        check(16'(d[7:0]), 16'h0000);
        // A frozen block must not catch a source pulse
        clk_en = 1'b0;
        pulse(8'h01);
        clk_en = 1'b1;
        tsl_host_model_inst.reg_read(ADDR_FLAGS, d);
        check(16'(d[7:0]), 16'h0000);
    endtask

    // Input-voltage flag: survives reads and writes of one, gated by the enable, cleared by zero
    task automatic t_vin();
        logic [15:0] d;
        logic ok;
        vin_en = 1'b1;
        pulse(8'h80);
        check(16'(alert_n), 16'h0000);
        tsl_host_model_inst.reg_read(ADDR_FLAGS, d);
        tsl_host_model_inst.reg_read(ADDR_FLAGS, d);
        check(16'({alert_n, d[7:0]}), 16'h0080);
        tsl_host_model_inst.reg_write(DEV_ADDR_DEFAULT, ADDR_FLAGS, 8'h80, ok);
        check(16'({ok, alert_n}), 16'h0002);
        vin_en = 1'b0;
        repeat (2) @(negedge clk_sys);
        check(16'(alert_n), 16'h0001);
        vin_en = 1'b1;
        repeat (2) @(negedge clk_sys);
        check(16'(alert_n), 16'h0000);
        tsl_host_model_inst.reg_write(DEV_ADDR_DEFAULT, ADDR_FLAGS, 8'h00, ok);
        repeat (2) @(negedge clk_sys);
        tsl_host_model_inst.reg_read(ADDR_FLAGS, d);
        check(16'({alert_n, d[7:0]}), 16'h0100);
    endtask

    // Limit in force: host value, optimizer beating a same-cycle host load, code zero
    task automatic t_limit();
        logic [15:0] d;
        logic ok;
        host_lim = 7'h15;
        host_load = 1'b1;
        @(negedge clk_sys);
        host_load = 1'b0;
        tsl_host_model_inst.reg_read(ADDR_LIMIT_LO, d);
        check(d, 16'h1500);
        check(16'(tsl_host_model_inst.limit_ma(d[14:8], 1'b1, 1'b0)), 16'h0834);
        check(16'(tsl_host_model_inst.limit_ma(d[14:8], 1'b0, 1'b1)), 16'h047e);
        ico_lim = 7'h7f;
        host_lim = 7'h01;
        ico_load = 1'b1;
        host_load = 1'b1;
        @(negedge clk_sys);
        ico_load = 1'b0;
        host_load = 1'b0;
        tsl_host_model_inst.reg_read(ADDR_LIMIT_LO, d);
        check(d, 16'h7f00);
        tsl_host_model_inst.reg_write(DEV_ADDR_DEFAULT, ADDR_LIMIT_HI, 8'h80, ok);
        tsl_host_model_inst.reg_write(DEV_ADDR_DEFAULT, ADDR_LIMIT_LO, 8'hff, ok);
        tsl_host_model_inst.reg_read(ADDR_LIMIT_LO, d);
        check(d, 16'h7f00);
        host_lim = 7'h00;
        host_load = 1'b1;
        @(negedge clk_sys);
        host_load = 1'b0;
        tsl_host_model_inst.reg_read(ADDR_LIMIT_LO, d);
        check(d, 16'h0000);
        check(16'(tsl_host_model_inst.limit_ma(d[14:8], 1'b0, 1'b0)), 16'h0032);
        check(16'(tsl_host_model_inst.limit_ma(d[14:8], 1'b1, 1'b1)), 16'h012c);
    endtask

    // Foreign target address is left unanswered; an unmapped pair reads zero
    task automatic t_addr();
        logic [15:0] d;
        logic ok;
        tsl_host_model_inst.reg_write(DEV_ADDR_DEFAULT ^ 7'h01, ADDR_FLAGS, 8'h00, ok);
        check(16'(ok), 16'h0000);
        tsl_host_model_inst.reg_read(8'h30, d);
        check(d, 16'h0000);
    endtask

    task automatic end_of_test();
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence: two reset cycles, then every scenario in turn
    initial begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        vin_en = 1'b0;
        src_event = 8'h00;
        host_lim = 7'h00;
        ico_lim = 7'h00;
        host_load = 1'b0;
        ico_load = 1'b0;
        repeat (2) @(negedge clk_sys);
        sys_rst = 1'b0;
        @(negedge clk_sys);
        t_reset();
        t_latched();
        t_vin();
        t_limit();
        t_addr();
        end_of_test();
    end
endmodule
`default_nettype wire
